// ---- safety_io_top.sv ----
// Safety I/O pins, analog mux select, fail-safe and reset output control.
// Assumes watchdog, fault and software strobes are one-cycle pulses on
// ref_clk; pins and the debug strap are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "safety_io_cfg.svh"
module safety_io_top #(
  parameter logic [`CNT_W-1:0] RST_SHORT_CYC = `RST_SHORT_US * `CLK_MHZ,
  parameter logic [`CNT_W-1:0] RST_MID_CYC   = `RST_MID_US * `CLK_MHZ,
  parameter logic [`CNT_W-1:0] RST_LONG_CYC  = `RST_LONGEST_US * `CLK_MHZ,
  parameter logic [`CNT_W-1:0] INIT_WIN_CYC  = `INIT_WIN_US * `CLK_MHZ
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rstn,
  input  wire logic [`NUM_IO-1:0]                   io_pin,
  input  wire safety_io_pkg::io_cfg_t [`NUM_IO-1:0] io_cfg,
  input  wire logic [1:0]                           gate_cmd,
  input  wire safety_io_pkg::mux_src_t              mux_request,
  input  wire logic                                 core_fb_check_en,
  input  wire logic [`FB_MV_W-1:0]                  vcore_fb_mv,
  input  wire logic [`FB_MV_W-1:0]                  io1_fb_mv,
  input  wire logic                                 debug_pin_in_window,
  input  wire logic                                 low_power_off_mode,
  input  wire logic                                 low_power_wake,
  input  wire logic                                 wd_good_refresh,
  input  wire logic                                 wd_error,
  input  wire logic                                 fault_fs,
  input  wire logic                                 fault_rst,
  input  wire logic                                 safe_output_release_field,
  input  wire logic                                 init_cfg_write,
  input  wire logic                                 init_cfg_long_sel,
  input  wire logic                                 status_clear,
  output logic                                      fail_safe_out_n,
  output logic                                      reset_out_n,
  output safety_io_pkg::fs_state_t                  fs_state,
  output logic                                      debug_mode,
  output logic                                      can_normal_force,
  output safety_io_pkg::mux_src_t                   analog_mux_output,
  output logic [1:0]                                analog_route_en,
  output logic [1:0]                                gate_out,
  output logic [`NUM_IO-1:0]                        digital_level,
  output logic                                      wake_request,
  output logic [`NUM_IO-1:0]                        wake_source,
  output safety_io_pkg::safety_status_t             safety_status
);

  logic [`NUM_IO-1:0] level;
  logic [`NUM_IO-1:0] wake_hit;
  logic               debug_level;

  // ========================================================================
  // Pin cells
  // wake sources
  for (genvar i = 0; i < `NUM_IO; i++) begin : g_pin
    io_pin_cell u_cell (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .pin_async  (io_pin[i]),
      .wake_en    (io_cfg[i].mode == safety_io_pkg::IO_WAKE),
      .wake_edge  (io_cfg[i].edge_sel),
      .level      (level[i]),
      .wake_event (wake_hit[i])
    );
  end

  io_pin_cell u_debug (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .pin_async  (debug_pin_in_window),
    .wake_en    (1'b0),
    .wake_edge  (safety_io_pkg::WAKE_ANY),
    .level      (debug_level),
    .wake_event ()
  );

  // ========================================================================
  // Debug strap
  // The strap is taken once after reset release; changing the pin later
  // has no effect until the next reset, so debug cannot end by accident.
  logic [1:0] strap_cnt;
  logic       strap_done;
  logic [1:0] next_strap_cnt;
  logic       next_strap_done;
  logic       next_debug_mode;

  always_comb begin
    next_strap_cnt  = strap_cnt;
    next_strap_done = strap_done;
    next_debug_mode = debug_mode;
    if (!strap_done) begin
      if (strap_cnt == `STRAP_WAIT) begin
        next_strap_done = 1'b1;
        next_debug_mode = debug_level;
      end else begin
        next_strap_cnt = strap_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt        <= 2'h0;
      strap_done       <= 1'b0;
      debug_mode       <= 1'b0;
      can_normal_force <= 1'b0;
    end else begin
      strap_cnt        <= next_strap_cnt;
      strap_done       <= next_strap_done;
      debug_mode       <= next_debug_mode;
      can_normal_force <= next_debug_mode;
    end
  end

  // ========================================================================
  // Safety inputs and core feedback
  logic                 pair01_on;
  logic                 pair23_on;
  logic                 pair45_on;
  logic                 pair01_bad;
  logic                 pair23_bad;
  logic                 pair45_bad;
  logic                 core_fb_bad;
  logic                 safety_event;
  logic [`FB_MV_W:0]    fb_diff;
  logic [`FB_MV_W:0]    fb_abs;
  safety_io_pkg::safety_status_t next_safety_status;

  always_comb begin
    pair01_on = (io_cfg[0].mode == safety_io_pkg::IO_SAFETY) &&
                (io_cfg[1].mode == safety_io_pkg::IO_SAFETY) &&
                !core_fb_check_en;
    pair23_on = (io_cfg[2].mode == safety_io_pkg::IO_SAFETY) &&
                (io_cfg[3].mode == safety_io_pkg::IO_SAFETY);
    pair45_on = (io_cfg[4].mode == safety_io_pkg::IO_SAFETY) &&
                (io_cfg[5].mode == safety_io_pkg::IO_SAFETY);
    pair01_bad = pair01_on && (level[0] == level[1]);
    pair23_bad = pair23_on && (level[2] == level[3]) &&
                 (fs_state == safety_io_pkg::ST_NORMAL_WD);
    pair45_bad = pair45_on && (level[4] == level[5]);
    fb_diff = {1'b0, vcore_fb_mv} - {1'b0, io1_fb_mv};
    fb_abs  = fb_diff[`FB_MV_W] ? (~fb_diff + 13'h0001) : fb_diff;
    core_fb_bad = core_fb_check_en && (fb_abs > `FB_DELTA_MV);
    safety_event = pair01_bad | pair23_bad | pair45_bad | core_fb_bad;
    next_safety_status = safety_status;
    if (status_clear) begin
      next_safety_status = '0;
    end
    next_safety_status.pair01_err  = next_safety_status.pair01_err  | pair01_bad;
    next_safety_status.pair23_err  = next_safety_status.pair23_err  | pair23_bad;
    next_safety_status.pair45_err  = next_safety_status.pair45_err  | pair45_bad;
    next_safety_status.core_fb_err = next_safety_status.core_fb_err | core_fb_bad;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      safety_status <= '0;
    end else begin
      safety_status <= next_safety_status;
    end
  end

  a_core_fb_flag: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    core_fb_check_en && (fb_abs > `FB_DELTA_MV) |=> safety_status.core_fb_err)
    else $error("core feedback drift not flagged");

  a_bistable_err: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    pair23_on && (level[2] == level[3]) &&
    (fs_state != safety_io_pkg::ST_NORMAL_WD) && !safety_status.pair23_err
    |=> !safety_status.pair23_err)
    else $error("IO2/IO3 evaluated outside normal state");

  // ========================================================================
  // Fail-safe state machine and reset output
  safety_io_pkg::fs_state_t next_fs_state;
  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] next_cnt;
  logic [`CNT_W-1:0] rst_target;
  logic [`CNT_W-1:0] next_rst_target;
  logic [`CNT_W-1:0] cfg_rst_cyc;
  logic              fs_init_config_one;
  logic              next_fs_init_config_one;
  logic              next_reset_out_n;
  logic              wd_fault;

  always_comb begin
    cfg_rst_cyc = fs_init_config_one ? RST_MID_CYC : RST_SHORT_CYC;
    wd_fault = wd_error && !debug_mode;
    next_fs_state           = fs_state;
    next_cnt                = cnt + 32'h00000001;
    next_rst_target         = rst_target;
    next_fs_init_config_one = fs_init_config_one;
    case (fs_state)
      safety_io_pkg::ST_RST_ACTIVE: begin
        if (cnt >= rst_target - 32'h00000001) begin
          next_fs_state = safety_io_pkg::ST_INIT_CFG;
          next_cnt      = '0;
        end
      end
      safety_io_pkg::ST_INIT_CFG: begin
        if (init_cfg_write) begin
          next_fs_init_config_one = init_cfg_long_sel;
        end
        if (fault_rst || (cnt >= INIT_WIN_CYC - 32'h00000001)) begin
          next_fs_state   = safety_io_pkg::ST_RST_ACTIVE;
          next_rst_target = cfg_rst_cyc;
          next_cnt        = '0;
        end else if (wd_good_refresh) begin
          next_fs_state = safety_io_pkg::ST_NORMAL_WD;
          next_cnt      = '0;
        end
      end
      default: begin
        next_cnt = '0;
        if (fault_rst || wd_fault) begin
          next_fs_state   = safety_io_pkg::ST_RST_ACTIVE;
          next_rst_target = cfg_rst_cyc;
        end
      end
    endcase
    if (low_power_wake) begin
      next_fs_state           = safety_io_pkg::ST_RST_ACTIVE;
      next_rst_target         = RST_LONG_CYC;
      next_cnt                = '0;
      next_fs_init_config_one = 1'b0;
    end
    next_reset_out_n = (next_fs_state != safety_io_pkg::ST_RST_ACTIVE);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fs_state           <= safety_io_pkg::ST_RST_ACTIVE;
      cnt                <= '0;
      rst_target         <= RST_LONG_CYC;
      fs_init_config_one <= 1'b0;
      reset_out_n        <= 1'b0;
    end else begin
      fs_state           <= next_fs_state;
      cnt                <= next_cnt;
      rst_target         <= next_rst_target;
      fs_init_config_one <= next_fs_init_config_one;
      reset_out_n        <= next_reset_out_n;
    end
  end

  a_rst_long_wake: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    low_power_wake |=> !reset_out_n && (rst_target == RST_LONG_CYC))
    else $error("wake did not start longest reset delay");

  a_rst_cfg_dur: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (fs_state == safety_io_pkg::ST_NORMAL_WD) && fault_rst && !low_power_wake
    |=> !reset_out_n && (rst_target == $past(cfg_rst_cyc)))
    else $error("fault reset did not use configured duration");

  a_init_lock: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (fs_state != safety_io_pkg::ST_INIT_CFG) && !low_power_wake
    |=> $stable(fs_init_config_one))
    else $error("reset duration changed outside init phase");

  a_wd_debug_ign: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    debug_mode && (fs_state == safety_io_pkg::ST_NORMAL_WD) && wd_error &&
    !fault_rst && !low_power_wake |=> fs_state == safety_io_pkg::ST_NORMAL_WD)
    else $error("watchdog error acted in debug mode");

  a_can_debug: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    strap_done && $stable(debug_mode) |-> can_normal_force == debug_mode)
    else $error("CAN not forced normal in debug mode");

  // ========================================================================
  // Fail-safe output
  // Release needs a good watchdog answer seen since rstn or the last wake, so
  // until then a runaway write of the release field alone cannot open the safe path.
  logic wd_answer_ok;
  logic dbg_released;
  logic next_wd_answer_ok;
  logic next_dbg_released;
  logic next_fail_safe_out_n;
  logic fs_trigger;

  always_comb begin
    next_wd_answer_ok    = wd_answer_ok | wd_good_refresh;
    next_dbg_released    = dbg_released;
    next_fail_safe_out_n = fail_safe_out_n;
    fs_trigger = fault_fs | safety_event |
                 (wd_fault && (fs_state == safety_io_pkg::ST_NORMAL_WD));
    if (safe_output_release_field && next_wd_answer_ok) begin
      next_fail_safe_out_n = 1'b1;
      next_dbg_released    = debug_mode;
    end
    if (fs_trigger && !(debug_mode && dbg_released)) begin
      next_fail_safe_out_n = 1'b0;
    end
    if (low_power_wake) begin
      next_fail_safe_out_n = 1'b0;
      next_wd_answer_ok    = 1'b0;
      next_dbg_released    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd_answer_ok    <= 1'b0;
      dbg_released    <= 1'b0;
      fail_safe_out_n <= 1'b0;
    end else begin
      wd_answer_ok    <= next_wd_answer_ok;
      dbg_released    <= next_dbg_released;
      fail_safe_out_n <= next_fail_safe_out_n;
    end
  end

  a_fs_trigger: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    fault_fs && !(debug_mode && dbg_released) |=> !fail_safe_out_n)
    else $error("fail-safe trigger did not drive output low");

  a_fs_wake_low: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    low_power_wake |=> !fail_safe_out_n [*1] ##0 !wd_answer_ok)
    else $error("fail-safe output not low after wake");

  a_fs_debug_hold: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    debug_mode && dbg_released && fail_safe_out_n && !low_power_wake
    |=> fail_safe_out_n)
    else $error("fail-safe reasserted after debug release");

  // ========================================================================
  // Analog mux, gate drivers, digital levels and wake source
  safety_io_pkg::mux_src_t next_mux;
  logic [1:0]              next_route_en;
  logic [1:0]              next_gate_out;
  logic [`NUM_IO-1:0]      next_digital_level;
  logic [`NUM_IO-1:0]      next_wake_source;
  logic                    next_wake_request;

  always_comb begin
    next_route_en[0] = io_cfg[0].mode == safety_io_pkg::IO_ANALOG;
    next_route_en[1] = io_cfg[1].mode == safety_io_pkg::IO_ANALOG;
    case (mux_request)
      safety_io_pkg::MUX_IO0:
        next_mux = next_route_en[0] ? mux_request : safety_io_pkg::MUX_REF;
      safety_io_pkg::MUX_IO1:
        next_mux = next_route_en[1] ? mux_request : safety_io_pkg::MUX_REF;
      safety_io_pkg::MUX_BATTERY,
      safety_io_pkg::MUX_TEMP:
        next_mux = mux_request;
      default:
        next_mux = safety_io_pkg::MUX_REF;
    endcase
    next_route_en[0] = next_route_en[0] && (next_mux == safety_io_pkg::MUX_IO0);
    next_route_en[1] = next_route_en[1] && (next_mux == safety_io_pkg::MUX_IO1);
    next_gate_out[0] = gate_cmd[0] && (io_cfg[4].mode == safety_io_pkg::IO_GATE);
    next_gate_out[1] = gate_cmd[1] && (io_cfg[5].mode == safety_io_pkg::IO_GATE);
    for (int i = 0; i < `NUM_IO; i++) begin
      next_digital_level[i] = level[i] &&
        (io_cfg[i].mode == safety_io_pkg::IO_DIGITAL);
    end
    next_wake_request = low_power_off_mode && (|wake_hit);
    next_wake_source  = status_clear ? '0 : wake_source;
    if (low_power_off_mode) begin
      next_wake_source = next_wake_source | wake_hit;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      analog_mux_output <= safety_io_pkg::MUX_REF;
      analog_route_en   <= 2'h0;
      gate_out          <= 2'h0;
      digital_level     <= '0;
      wake_source       <= '0;
      wake_request      <= 1'b0;
    end else begin
      analog_mux_output <= next_mux;
      analog_route_en   <= next_route_en;
      gate_out          <= next_gate_out;
      digital_level     <= next_digital_level;
      wake_source       <= next_wake_source;
      wake_request      <= next_wake_request;
    end
  end

  a_mux_one_src: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $onehot0(analog_route_en) &&
    !(analog_route_en[0] && (analog_mux_output != safety_io_pkg::MUX_IO0)) &&
    !(analog_route_en[1] && (analog_mux_output != safety_io_pkg::MUX_IO1)))
    else $error("analog pin routed while another source selected");

  a_wake_latch: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    low_power_off_mode && (wake_hit != '0) |=> wake_request &&
    ((wake_source & $past(wake_hit)) == $past(wake_hit)))
    else $error("wake source not latched");

endmodule
`default_nettype wire

// ---- safety_io_cfg.svh ----
// Timing, threshold and width constants of the safety I/O block.
// Assumes one 50 MHz clock and millivolt feedback codes on the same clock.
`ifndef SAFETY_IO_CFG_SVH
`define SAFETY_IO_CFG_SVH

// ==========================================================================
// Clock and times
`define CLK_MHZ        50
`define RST_SHORT_US   1000
`define RST_MID_US     10000
`define RST_LONGEST_US 20000
`define INIT_WIN_US    256000

// ==========================================================================
// Thresholds and widths
`define NUM_IO         6
`define FB_MV_W        12
`define FB_DELTA_MV    13'h0096
`define STRAP_WAIT     2'h3
`define PIN_SETTLE     2'h3
`define CNT_W          32

`endif

// ---- safety_io_pkg.sv ----
// Types shared by the safety I/O block and its pin cell.
// Assumes nothing of its surroundings.
`default_nettype none
package safety_io_pkg;

  // ========================================================================
  // Pin configuration
  typedef enum logic [2:0] {
    IO_OFF, IO_ANALOG, IO_DIGITAL, IO_WAKE, IO_SAFETY, IO_GATE
  } io_mode_t;

  typedef enum logic [1:0] {WAKE_RISE, WAKE_FALL, WAKE_ANY} wake_edge_t;

  typedef struct packed {
    io_mode_t   mode;
    wake_edge_t edge_sel;
  } io_cfg_t;

  // ========================================================================
  // Mux sources, fail-safe states and status
  typedef enum logic [2:0] {
    MUX_BATTERY, MUX_IO0, MUX_IO1, MUX_REF, MUX_TEMP
  } mux_src_t;

  typedef enum logic [1:0] {ST_RST_ACTIVE, ST_INIT_CFG, ST_NORMAL_WD} fs_state_t;

  typedef struct packed {
    logic pair01_err;
    logic pair23_err;
    logic pair45_err;
    logic core_fb_err;
  } safety_status_t;

endpackage
`default_nettype wire

// ---- io_pin_cell.sv ----
// One multi-purpose pin: two-stage synchroniser and wake edge detection.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "safety_io_cfg.svh"
module io_pin_cell (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    pin_async,
  input  wire logic                    wake_en,
  input  wire safety_io_pkg::wake_edge_t wake_edge,
  output logic                         level,
  output logic                         wake_event
);

  logic       meta;
  logic       prev;
  logic       next_wake_event;
  logic [1:0] settle;
  logic [1:0] next_settle;

  // ========================================================================
  // Edge selection
  // Edges are ignored until prev holds a real pin level, so a pin that
  // idles high after reset does not raise a false wake.
  // wake edge select
  always_comb begin
    next_settle     = settle;
    next_wake_event = 1'b0;
    if (settle != `PIN_SETTLE) begin
      next_settle = settle + 2'h1;
    end
    if (wake_en && (settle == `PIN_SETTLE)) begin
      case (wake_edge)
        safety_io_pkg::WAKE_RISE: next_wake_event = level & ~prev;
        safety_io_pkg::WAKE_FALL: next_wake_event = ~level & prev;
        default:                  next_wake_event = level ^ prev;
      endcase
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta       <= 1'b0;
      settle     <= 2'h0;
      level      <= 1'b0;
      prev       <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      meta       <= pin_async;
      settle     <= next_settle;
      level      <= meta;
      prev       <= level;
      wake_event <= next_wake_event;
    end
  end

endmodule
`default_nettype wire

// ---- mcu_model.sv ----
// Microcontroller model: first watchdog refresh and fail-safe release.
// Assumes it shares ref_clk with the block and answers after resp_dly edges.
`timescale 1ns/100ps
`default_nettype none
module mcu_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_out_n,
  input  wire logic [7:0] resp_dly,
  output logic            wd_good_refresh,
  output logic            release_req
);
  // ==========================================================================
  // Refresh and release after every reset
  initial begin
    wd_good_refresh = 1'b0;
    release_req = 1'b0;
    forever begin
      @(posedge reset_out_n);
      repeat (resp_dly) @(posedge ref_clk);
      #1 wd_good_refresh = 1'b1;
      @(posedge ref_clk) #1 wd_good_refresh = 1'b0;
      @(posedge ref_clk) #1 release_req = 1'b1;
      @(posedge ref_clk) #1 release_req = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- safety_io_top_test.sv ----
// Self-checking bench for the safety I/O block and a microcontroller model.
// Assumes short reset counts so that the whole run stays brief.
`timescale 1ns/100ps
`default_nettype none
module safety_io_top_test;
  // ==========================================================================
  // Signals
  logic ref_clk, rstn, fb_en, dbg_win, lp_mode, lp_wake, wd_err, f_fs, f_rst;
  logic init_wr, long_sel, st_clr, wd_ok, rel, fsafe_n, rst_out_n;
  logic dbg, can_f, wreq;
  logic [5:0] pins, dig, wsrc;
  logic [1:0] gate_cmd, route, gate_o;
  logic [11:0] vfb, io1fb;
  logic [7:0] dly;
  safety_io_pkg::io_cfg_t [5:0] cfg;
  safety_io_pkg::mux_src_t mux_req, mux_o;
  safety_io_pkg::fs_state_t st;
  safety_io_pkg::safety_status_t stat;
  int err_count, n_checks, n;

  // Short counts: 20, 40, 60 and 200 cycles keep every wait small.
  safety_io_top #(.RST_SHORT_CYC(32'h14), .RST_MID_CYC(32'h28),
    .RST_LONG_CYC(32'h3C), .INIT_WIN_CYC(32'hC8)) u_safety_io_top (
    .ref_clk(ref_clk), .rstn(rstn), .io_pin(pins), .io_cfg(cfg),
    .gate_cmd(gate_cmd), .mux_request(mux_req), .core_fb_check_en(fb_en),
    .vcore_fb_mv(vfb), .io1_fb_mv(io1fb), .debug_pin_in_window(dbg_win),
    .low_power_off_mode(lp_mode), .low_power_wake(lp_wake),
    .wd_good_refresh(wd_ok), .wd_error(wd_err), .fault_fs(f_fs),
    .fault_rst(f_rst), .safe_output_release_field(rel),
    .init_cfg_write(init_wr), .init_cfg_long_sel(long_sel),
    .status_clear(st_clr), .fail_safe_out_n(fsafe_n),
    .reset_out_n(rst_out_n), .fs_state(st), .debug_mode(dbg),
    .can_normal_force(can_f), .analog_mux_output(mux_o),
    .analog_route_en(route), .gate_out(gate_o), .digital_level(dig),
    .wake_request(wreq), .wake_source(wsrc), .safety_status(stat));

  mcu_model u_mcu_model (.ref_clk(ref_clk), .reset_out_n(rst_out_n),
    .resp_dly(dly), .wd_good_refresh(wd_ok), .release_req(rel));

  // ==========================================================================
  // Helpers
  task chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // Bounded wait, so a stuck reset output ends the run instead of hanging.
  task low_len(output int len);
    len = 0;
    while (rst_out_n !== 1'b1 && len < 1000) begin
      step(1);
      len++;
    end
    if (len >= 1000) begin
      chk(1'b0, "reset output stuck");
      results();
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task t_startup;
    chk(fsafe_n === 1'b0 && rst_out_n === 1'b0, "outputs not low");
    low_len(n);
    chk(n >= 58 && n <= 62, "longest delay wrong");
    chk(dbg === 1'b0 && can_f === 1'b0, "debug without strap");
    init_wr = 1'b1;
    long_sel = 1'b1;
    step(1);
    init_wr = 1'b0;
    step(12);
    chk(st === safety_io_pkg::ST_NORMAL_WD, "no normal state");
    chk(fsafe_n === 1'b1, "no release");
    $display("startup done");
  endtask

  task t_faults;
    f_fs = 1'b1;
    step(1);
    f_fs = 1'b0;
    chk(fsafe_n === 1'b0, "fail-safe trigger ignored");
    f_rst = 1'b1;
    step(1);
    f_rst = 1'b0;
    low_len(n);
    chk(n >= 38 && n <= 42, "configured delay wrong");
    step(12);
    chk(fsafe_n === 1'b1, "no release after reset");
    lp_wake = 1'b1;
    step(1);
    lp_wake = 1'b0;
    chk(fsafe_n === 1'b0, "fail-safe high after wake");
    low_len(n);
    chk(n >= 58 && n <= 62, "wake delay wrong");
    step(12);
    wd_err = 1'b1;
    step(1);
    wd_err = 1'b0;
    chk(rst_out_n === 1'b0 && fsafe_n === 1'b0, "wd error ignored");
    low_len(n);
    chk(n >= 18 && n <= 22, "short delay wrong");
    step(12);
    $display("faults done");
  endtask

  task t_pins;
    cfg[0] = '{safety_io_pkg::IO_ANALOG, safety_io_pkg::WAKE_RISE};
    cfg[1] = '{safety_io_pkg::IO_ANALOG, safety_io_pkg::WAKE_RISE};
    cfg[2] = '{safety_io_pkg::IO_DIGITAL, safety_io_pkg::WAKE_RISE};
    cfg[4] = '{safety_io_pkg::IO_GATE, safety_io_pkg::WAKE_RISE};
    gate_cmd = 2'h3;
    pins[2] = 1'b1;
    for (int s = 0; s < 5; s++) begin
      mux_req = safety_io_pkg::mux_src_t'(s);
      step(2);
      chk(mux_o === mux_req, "mux source wrong");
      chk(route === {s == 2, s == 1}, "analog route wrong");
    end
    chk(dig === 6'h04, "digital level wrong");
    chk(gate_o === 2'h1, "gate drive wrong");
    lp_mode = 1'b1;
    for (int e = 0; e < 3; e++) begin
      cfg[3] = '{safety_io_pkg::IO_WAKE, safety_io_pkg::wake_edge_t'(e)};
      st_clr = 1'b1;
      step(1);
      st_clr = 1'b0;
      pins[3] = ~pins[3];
      step(4);
      chk(wreq === 1'b1, "no wake request");
      step(2);
      chk(wsrc === 6'h08 && wreq === 1'b0, "wake edge missed");
    end
    fb_en = 1'b1;
    io1fb = 12'h47E;
    step(3);
    chk(stat.core_fb_err === 1'b0, "false feedback error");
    io1fb = 12'h47F;
    step(2);
    chk(stat.core_fb_err === 1'b1, "feedback drift missed");
    fb_en = 1'b0;
    cfg[0] = '{safety_io_pkg::IO_SAFETY, safety_io_pkg::WAKE_RISE};
    cfg[1] = '{safety_io_pkg::IO_SAFETY, safety_io_pkg::WAKE_RISE};
    cfg[4] = '{safety_io_pkg::IO_SAFETY, safety_io_pkg::WAKE_RISE};
    cfg[5] = '{safety_io_pkg::IO_SAFETY, safety_io_pkg::WAKE_RISE};
    step(6);
    chk(stat === 4'hB, "pair error missed");
    $display("pins done");
  endtask

  // Mid-run reset with the strap inside its window, so debug must latch.
  task t_debug;
    dbg_win = 1'b1;
    lp_mode = 1'b0;
    rstn = 1'b0;
    cfg = '0;
    cfg[2] = '{safety_io_pkg::IO_SAFETY, safety_io_pkg::WAKE_RISE};
    cfg[3] = '{safety_io_pkg::IO_SAFETY, safety_io_pkg::WAKE_RISE};
    pins = 6'h00;
    step(3);
    rstn = 1'b1;
    chk(fsafe_n === 1'b0, "fail-safe high after reset");
    low_len(n);
    chk(dbg === 1'b1 && can_f === 1'b1, "no debug mode");
    chk(stat.pair23_err === 1'b0, "pair checked outside normal");
    pins = 6'h04;
    step(12);
    chk(fsafe_n === 1'b1, "no release in debug");
    pins = 6'h00;
    wd_err = 1'b1;
    f_fs = 1'b1;
    step(1);
    wd_err = 1'b0;
    f_fs = 1'b0;
    step(4);
    chk(stat.pair23_err === 1'b1, "bi-stable error missed");
    chk(fsafe_n === 1'b1, "fail-safe reasserted in debug");
    chk(rst_out_n === 1'b1, "watchdog error acted in debug");
    $display("debug done");
  endtask

  // ==========================================================================
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    {rstn, fb_en, dbg_win, lp_mode, lp_wake, wd_err, f_fs, f_rst} = '0;
    {init_wr, long_sel, st_clr} = '0;
    {err_count, n_checks} = '0;
    pins = 6'h00;
    cfg = '0;
    gate_cmd = 2'h0;
    mux_req = safety_io_pkg::MUX_BATTERY;
    vfb = 12'h3E8;
    io1fb = 12'h3E8;
    dly = 8'h05;
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_startup();
    t_faults();
    t_pins();
    t_debug();
    results();
  end
endmodule
`default_nettype wire
